// File: jdac_defs.vh
// Constants for the jack detection and activity configuration block.
// Assumes an 8-bit register port and a 100 MHz core clock.
`ifndef JDAC_DEFS_VH
`define JDAC_DEFS_VH

`define JDAC_ADDR_DEB_CFG 8'h1B
`define JDAC_ADDR_JACK_STAT 8'h1C
`define JDAC_ADDR_ACT_DET 8'h1E
`define JDAC_ADDR_ACT_GEN 8'h1F

`define JDAC_RST_DEB_CFG 8'h00
`define JDAC_RST_ACT_DET 8'h20
`define JDAC_RST_ACT_GEN 8'h80

// Writable bit masks; read-only reserved bits stay zero
`define JDAC_WMASK_DEB_CFG 8'h7F
`define JDAC_WMASK_ACT_DET 8'hFB
`define JDAC_WMASK_ACT_GEN 8'hE0

// Field positions
`define JDAC_HP_DEB_BIT 6
`define JDAC_INS_DEB_LSB 3
`define JDAC_REM_DEB_BIT 2
`define JDAC_HOOK_DEB_LSB 0
`define JDAC_JACK_TYPE_LSB 6
`define JDAC_HS_KIND_LSB 4
`define JDAC_ADC_MODE_LSB 6
`define JDAC_MON_CH_LSB 4
`define JDAC_SDO_IRQ_BIT 3
`define JDAC_REC_DET_BIT 1
`define JDAC_GEN_CH_LSB 6

// Debounce counts in detections; the insertion base count is in ms ticks
`define JDAC_HP_DEB_COUNT 10'h003
`define JDAC_REM_DEB_LONG 10'h005
`define JDAC_REM_DEB_SHORT 10'h003
`define JDAC_HOOK_DEB_TWO 10'h002
`define JDAC_HOOK_DEB_THREE 10'h003
`define JDAC_NO_DEB_COUNT 10'h001
`define JDAC_INS_BASE_MS 10'h010
`define JDAC_INS_MAX_CODE 3'h5

// Jack type codes
`define JDAC_JACK_NONE 2'h0
`define JDAC_JACK_NO_MIC 2'h1
`define JDAC_JACK_MIC 2'h3

// ADC power modes
`define JDAC_MODE_SW 2'h0
`define JDAC_MODE_ACT 2'h1
`define JDAC_MODE_MIXED 2'h2

// Timing
`define JDAC_CLK_PERIOD_NS 10
`define JDAC_MS_TIME_NS 1000000
`define JDAC_MS_CYCLES (`JDAC_MS_TIME_NS / `JDAC_CLK_PERIOD_NS)

`endif

// File: jdac_debounce.v
// Counts consecutive equal samples of a detector input.
// Assumes sampleTick is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
module jdac_debounce #(
    parameter DW = 1,
    parameter CW = 10
) (
    input wire clk,
    input wire rst_b,
    input wire clear,
    input wire sampleTick,
    input wire [DW-1:0] sampleIn,
    input wire [CW-1:0] needCount,
    output wire [DW-1:0] stableOut,
    output wire met
);
    reg [DW-1:0] last_q;
    reg [CW-1:0] count_q;

    assign stableOut = last_q;
    assign met = (count_q != {CW{1'b0}}) && (count_q >= needCount);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= {DW{1'b0}};
            count_q <= {CW{1'b0}};
        end else if (clear) begin
            count_q <= {CW{1'b0}};
        end else if (sampleTick) begin
            last_q <= sampleIn;
            if ((count_q != {CW{1'b0}}) && (sampleIn == last_q)) begin
                // Saturate so a long stable input keeps met high
                if (count_q != {CW{1'b1}}) begin
                    count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
                end
            end else begin
                count_q <= {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // jdac_debounce

// File: jdac_regs.v
// Register bank and status logic for jack detection and activity control.
// Assumes detector inputs are synchronous and detTick marks each detection.
`timescale 1ns/1ps
`include "jdac_defs.vh"
module jdac_regs #(
    parameter MS_CYCLES = `JDAC_MS_CYCLES
) (
    input wire clk,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output reg [7:0] regRdData_q,
    input wire headsetDetectEnable,
    input wire detTick,
    input wire jackPresentRaw,
    input wire micPresentRaw,
    input wire [1:0] headsetKindRaw,
    input wire hookRaw,
    input wire activityStart,
    input wire activityEnd,
    input wire adcRecording,
    input wire swAdcPowerUp,
    input wire swAdcPowerDown,
    output reg [1:0] jackTypeStatus_q,
    output reg [1:0] headsetKindStatus_q,
    output reg hookPressed_q,
    output reg adcPowerOn_q,
    output reg activityProcEnable_q,
    output reg [3:0] monitoredChannelMask_q,
    output reg [3:0] generatedChannelMask_q,
    output reg serialOutIrq_q,
    output reg serialOutIrqOe_q
);
    localparam ADC_OFF = 1'b0;
    localparam ADC_ON = 1'b1;

    reg [7:0] debCfg_q;
    reg [7:0] actDetCfg_q;
    reg [7:0] actGenCfg_q;
    reg [16:0] msCount_q;
    reg msTick_q;
    reg activityPending_q;
    reg adcState_q;
    reg adcState_d;
    reg [1:0] jackType_d;
    reg [1:0] headsetKind_d;
    reg hook_d;

    wire headphoneDebounceSel = debCfg_q[`JDAC_HP_DEB_BIT];
    wire [2:0] insertionDebounceSel = debCfg_q[`JDAC_INS_DEB_LSB +: 3];
    wire removalDebounceSel = debCfg_q[`JDAC_REM_DEB_BIT];
    wire [1:0] hookButtonDebounceSel = debCfg_q[`JDAC_HOOK_DEB_LSB +: 2];
    wire [1:0] autoAdcPowerMode = actDetCfg_q[`JDAC_ADC_MODE_LSB +: 2];
    wire [1:0] monitoredChannelSel = actDetCfg_q[`JDAC_MON_CH_LSB +: 2];
    wire serialOutIrqEnable = actDetCfg_q[`JDAC_SDO_IRQ_BIT];
    wire recordTimeDetectEnable = actDetCfg_q[`JDAC_REC_DET_BIT];
    wire [1:0] generatedActivityChannelSel = actGenCfg_q[`JDAC_GEN_CH_LSB +: 2];

    function [3:0] chan_onehot;
        input [1:0] sel;
        begin
            chan_onehot = 4'h1 << sel;
        end
    endfunction

    // Codes six and seven both fall back to a single detection
    function [9:0] insert_need;
        input [2:0] code;
        begin
            if (code <= `JDAC_INS_MAX_CODE) begin
                insert_need = `JDAC_INS_BASE_MS << code;
            end else begin
                insert_need = `JDAC_NO_DEB_COUNT;
            end
        end
    endfunction

    function [9:0] hook_need;
        input [1:0] code;
        begin
            case (code)
                2'h2: hook_need = `JDAC_HOOK_DEB_TWO;
                2'h3: hook_need = `JDAC_HOOK_DEB_THREE;
                default: hook_need = `JDAC_NO_DEB_COUNT;
            endcase
        end
    endfunction

    // Millisecond time base for insertion debounce
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            msCount_q <= 17'h00000;
            msTick_q <= 1'b0;
        end else if (msCount_q >= MS_CYCLES[16:0] - 17'h00001) begin
            msCount_q <= 17'h00000;
            msTick_q <= 1'b1;
        end else begin
            msCount_q <= msCount_q + 17'h00001;
            msTick_q <= 1'b0;
        end
    end

    wire detClear = !headsetDetectEnable;
    wire insNoDeb = (insertionDebounceSel > `JDAC_INS_MAX_CODE);
    wire insTick = insNoDeb ? detTick : msTick_q;
    wire [9:0] hpNeed = headphoneDebounceSel ? `JDAC_HP_DEB_COUNT : `JDAC_NO_DEB_COUNT;
    wire [9:0] remNeed = removalDebounceSel ? `JDAC_REM_DEB_SHORT : `JDAC_REM_DEB_LONG;
    wire [1:0] hpStable;
    wire hpMet;
    wire insStable;
    wire insMet;
    wire remStable;
    wire remMet;
    wire hookStable;
    wire hookMet;

    jdac_debounce #(.DW(2), .CW(10)) u_hp_deb (
        .clk(clk),
        .rst_b(rst_b),
        .clear(detClear),
        .sampleTick(detTick),
        .sampleIn(headsetKindRaw),
        .needCount(hpNeed),
        .stableOut(hpStable),
        .met(hpMet)
    );

    jdac_debounce #(.DW(1), .CW(10)) u_ins_deb (
        .clk(clk),
        .rst_b(rst_b),
        .clear(detClear),
        .sampleTick(insTick),
        .sampleIn(jackPresentRaw),
        .needCount(insert_need(insertionDebounceSel)),
        .stableOut(insStable),
        .met(insMet)
    );

    jdac_debounce #(.DW(1), .CW(10)) u_rem_deb (
        .clk(clk),
        .rst_b(rst_b),
        .clear(detClear),
        .sampleTick(detTick),
        .sampleIn(jackPresentRaw),
        .needCount(remNeed),
        .stableOut(remStable),
        .met(remMet)
    );

    jdac_debounce #(.DW(1), .CW(10)) u_hook_deb (
        .clk(clk),
        .rst_b(rst_b),
        .clear(detClear),
        .sampleTick(detTick),
        .sampleIn(hookRaw),
        .needCount(hook_need(hookButtonDebounceSel)),
        .stableOut(hookStable),
        .met(hookMet)
    );

    always @* begin
        jackType_d = jackTypeStatus_q;
        headsetKind_d = headsetKindStatus_q;
        hook_d = hookPressed_q;
        if (headsetDetectEnable) begin
            if (jackTypeStatus_q == `JDAC_JACK_NONE) begin
                if (insMet && insStable) begin
                    jackType_d = micPresentRaw ? `JDAC_JACK_MIC : `JDAC_JACK_NO_MIC;
                end
            end else if (remMet && !remStable) begin
                jackType_d = `JDAC_JACK_NONE;
                headsetKind_d = 2'h0;
                hook_d = 1'b0;
            end else begin
                if (hpMet) begin
                    headsetKind_d = hpStable;
                end
                if (hookMet) begin
                    hook_d = hookStable;
                end
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jackTypeStatus_q <= `JDAC_JACK_NONE;
            headsetKindStatus_q <= 2'h0;
            hookPressed_q <= 1'b0;
        end else begin
            jackTypeStatus_q <= jackType_d;
            headsetKindStatus_q <= headsetKind_d;
            hookPressed_q <= hook_d;
        end
    end

    wire actEnable = !adcRecording || recordTimeDetectEnable;
    wire actStart = activityStart && actEnable;
    wire actEnd = activityEnd && actEnable;

    always @* begin
        adcState_d = adcState_q;
        case (autoAdcPowerMode)
            `JDAC_MODE_SW: begin
                if (swAdcPowerUp) begin
                    adcState_d = ADC_ON;
                end else if (swAdcPowerDown) begin
                    adcState_d = ADC_OFF;
                end
            end
            `JDAC_MODE_ACT: begin
                if (actStart) begin
                    adcState_d = ADC_ON;
                end else if (actEnd) begin
                    adcState_d = ADC_OFF;
                end
            end
            `JDAC_MODE_MIXED: begin
                if (actStart) begin
                    adcState_d = ADC_ON;
                end else if (swAdcPowerDown) begin
                    adcState_d = ADC_OFF;
                end
            end
            // Forbidden mode holds the current state
            default: adcState_d = adcState_q;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adcState_q <= ADC_OFF;
            adcPowerOn_q <= 1'b0;
            activityProcEnable_q <= 1'b0;
            activityPending_q <= 1'b0;
            serialOutIrq_q <= 1'b0;
            serialOutIrqOe_q <= 1'b0;
            monitoredChannelMask_q <= 4'h4;
            generatedChannelMask_q <= 4'h4;
        end else begin
            adcState_q <= adcState_d;
            adcPowerOn_q <= (adcState_d == ADC_ON);
            activityProcEnable_q <= actEnable;
            // Set wins over clear in the same cycle
            if (actStart) begin
                activityPending_q <= 1'b1;
            end else if (actEnd) begin
                activityPending_q <= 1'b0;
            end
            serialOutIrqOe_q <= serialOutIrqEnable && !adcRecording;
            serialOutIrq_q <= serialOutIrqEnable && !adcRecording && (activityPending_q || actStart);
            monitoredChannelMask_q <= chan_onehot(monitoredChannelSel);
            generatedChannelMask_q <= chan_onehot(generatedActivityChannelSel);
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            debCfg_q <= `JDAC_RST_DEB_CFG;
            actDetCfg_q <= `JDAC_RST_ACT_DET;
            actGenCfg_q <= `JDAC_RST_ACT_GEN;
        end else if (regWrEn) begin
            case (regAddr)
                `JDAC_ADDR_DEB_CFG: debCfg_q <= regWrData & `JDAC_WMASK_DEB_CFG;
                `JDAC_ADDR_ACT_DET: actDetCfg_q <= regWrData & `JDAC_WMASK_ACT_DET;
                `JDAC_ADDR_ACT_GEN: actGenCfg_q <= regWrData & `JDAC_WMASK_ACT_GEN;
                default: debCfg_q <= debCfg_q;
            endcase
        end
    end

    // Unmapped addresses read as zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_q <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `JDAC_ADDR_DEB_CFG: regRdData_q <= debCfg_q;
                `JDAC_ADDR_JACK_STAT: regRdData_q <= {jackTypeStatus_q, headsetKindStatus_q, 4'h0};
                `JDAC_ADDR_ACT_DET: regRdData_q <= actDetCfg_q;
                `JDAC_ADDR_ACT_GEN: regRdData_q <= actGenCfg_q;
                default: regRdData_q <= 8'h00;
            endcase
        end
    end
endmodule // jdac_regs

// File: jdac_regs_asserts.sv
// Port-level checks for the jack detection and activity register block.
// Assumes binding to jdac_regs; one clock domain, async active-low reset.
`timescale 1ns/1ps
module jdac_regs_chk #(
    parameter MS_CYCLES = 100000
) (
    input wire clk,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    input wire [7:0] regRdData_q,
    input wire headsetDetectEnable,
    input wire detTick,
    input wire jackPresentRaw,
    input wire micPresentRaw,
    input wire [1:0] headsetKindRaw,
    input wire hookRaw,
    input wire activityStart,
    input wire activityEnd,
    input wire adcRecording,
    input wire swAdcPowerUp,
    input wire swAdcPowerDown,
    input wire [1:0] jackTypeStatus_q,
    input wire [1:0] headsetKindStatus_q,
    input wire hookPressed_q,
    input wire adcPowerOn_q,
    input wire activityProcEnable_q,
    input wire [3:0] monitoredChannelMask_q,
    input wire [3:0] generatedChannelMask_q,
    input wire serialOutIrq_q,
    input wire serialOutIrqOe_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire mapped = regAddr == 8'h1B || regAddr == 8'h1C || regAddr == 8'h1E || regAddr == 8'h1F;
    sequence s_wrDet; regWrEn && regAddr == 8'h1E ##1 !regWrEn; endsequence
    sequence s_wrGen; regWrEn && regAddr == 8'h1F ##1 !regWrEn; endsequence
    // Decode lags the register by one cycle
    a_mon_decode: assert property (s_wrDet |=> monitoredChannelMask_q == (4'h1 << $past(regWrData[5:4], 2)))
        else $error("monitored channel mask wrong");
    a_gen_decode: assert property (s_wrGen |=> generatedChannelMask_q == (4'h1 << $past(regWrData[7:6], 2)))
        else $error("generated channel mask wrong");
    a_rd_unmapped: assert property (regRdEn && !mapped |=> regRdData_q == 8'h00)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!regRdEn |=> $stable(regRdData_q))
        else $error("read data moved without read");
    a_rd_status: assert property (regRdEn && regAddr == 8'h1C |=>
        regRdData_q == {$past(jackTypeStatus_q), $past(headsetKindStatus_q), 4'h0})
        else $error("status read mismatch");
    a_jack_legal: assert property (jackTypeStatus_q != 2'h2)
        else $error("reserved jack type code");
    a_kind_jack: assert property (jackTypeStatus_q == 2'h0 [*2] |-> headsetKindStatus_q == 2'h0 && !hookPressed_q)
        else $error("kind or hook without jack");
    a_hold_off: assert property (!headsetDetectEnable [*2] |=> $stable(jackTypeStatus_q) &&
        $stable(headsetKindStatus_q) && $stable(hookPressed_q))
        else $error("status moved while detection off");
    a_oe_rec: assert property (adcRecording |=> !serialOutIrqOe_q)
        else $error("pin driven while recording");
    // Reset still sampled low on the release edge
    a_proc_en: assert property (rst_b && !adcRecording |=> activityProcEnable_q)
        else $error("processing off while idle");
endmodule // jdac_regs_chk

// File: jack_detect_activity_cfg_tb.sv
// Self-checking bench for jdac_regs through its register strobes and pins.
// Assumes jdac_regs_asserts.sv is compiled first; ms tick shortened to 10 clocks.
`timescale 1ns/1ps
module jack_detect_activity_cfg_tb;
    localparam MSC = 10;
    logic clk, rst_b, regWrEn, regRdEn, headsetDetectEnable, detTick, jackPresentRaw, micPresentRaw, hookRaw;
    logic activityStart, activityEnd, adcRecording, swAdcPowerUp, swAdcPowerDown;
    logic hookPressed_q, adcPowerOn_q, activityProcEnable_q, serialOutIrq_q, serialOutIrqOe_q;
    logic [7:0] regAddr, regWrData, regRdData_q;
    logic [1:0] headsetKindRaw, jackTypeStatus_q, headsetKindStatus_q;
    logic [3:0] monitoredChannelMask_q, generatedChannelMask_q;
    int errCount = 0, numChecks = 0, cycles = 0;
    jdac_regs #(.MS_CYCLES(MSC)) i_dut (
        .clk(clk),
        .rst_b(rst_b),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdEn(regRdEn),
        .regRdData_q(regRdData_q),
        .headsetDetectEnable(headsetDetectEnable),
        .detTick(detTick),
        .jackPresentRaw(jackPresentRaw),
        .micPresentRaw(micPresentRaw),
        .headsetKindRaw(headsetKindRaw),
        .hookRaw(hookRaw),
        .activityStart(activityStart),
        .activityEnd(activityEnd),
        .adcRecording(adcRecording),
        .swAdcPowerUp(swAdcPowerUp),
        .swAdcPowerDown(swAdcPowerDown),
        .jackTypeStatus_q(jackTypeStatus_q),
        .headsetKindStatus_q(headsetKindStatus_q),
        .hookPressed_q(hookPressed_q),
        .adcPowerOn_q(adcPowerOn_q),
        .activityProcEnable_q(activityProcEnable_q),
        .monitoredChannelMask_q(monitoredChannelMask_q),
        .generatedChannelMask_q(generatedChannelMask_q),
        .serialOutIrq_q(serialOutIrq_q),
        .serialOutIrqOe_q(serialOutIrqOe_q)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run takes about 400 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            tallyAndFinish();
        end
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tallyAndFinish;
        $display("Checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(posedge clk);
        #1 chk("regRdData", regRdData_q, exp);
    endtask
    // Detector levels {enable, present, mic, kind, hook}, then n detections
    task tick(input int n, input logic [5:0] v);
        @(posedge clk);
        {headsetDetectEnable, jackPresentRaw, micPresentRaw, headsetKindRaw, hookRaw} <= v;
        repeat (n) begin
            @(posedge clk);
            detTick <= 1'b1;
            @(posedge clk);
            detTick <= 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    task sts(input logic [7:0] e);
        chk("status", {jackTypeStatus_q, headsetKindStatus_q, hookPressed_q, 3'h0}, e);
    endtask
    // Pulses {start, end, swUp, swDown}
    task act(input logic [3:0] p, input logic e);
        @(posedge clk);
        {activityStart, activityEnd, swAdcPowerUp, swAdcPowerDown} <= p;
        @(posedge clk);
        {activityStart, activityEnd, swAdcPowerUp, swAdcPowerDown} <= 4'h0;
        #1 chk("adcPowerOn", {7'h0, adcPowerOn_q}, {7'h0, e});
    endtask
    initial begin
        {rst_b, regWrEn, regRdEn, headsetDetectEnable, detTick, jackPresentRaw, micPresentRaw, hookRaw} = 8'h00;
        {activityStart, activityEnd, adcRecording, swAdcPowerUp, swAdcPowerDown} = 5'h00;
        {regAddr, regWrData, headsetKindRaw} = 18'h00000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk("chMasks", {monitoredChannelMask_q, generatedChannelMask_q}, 8'h44);
        rd(8'h1B, 8'h00);
        rd(8'h1C, 8'h00);
        rd(8'h1E, 8'h20);
        rd(8'h1F, 8'h80);
        wr(8'h1B, 8'hFF);
        rd(8'h1B, 8'h7F);
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h00);
        wr(8'h1E, 8'hFF);
        rd(8'h1E, 8'hFB);
        wr(8'h1F, 8'hFF);
        rd(8'h1F, 8'hE0);
        wr(8'h1D, 8'hFF);
        rd(8'h1D, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h1E, 8'(c << 4));
            wr(8'h1F, 8'(c << 6));
            repeat (2) @(posedge clk);
            #1 chk("chMasks", {monitoredChannelMask_q, generatedChannelMask_q}, {4'h1 << c, 4'h1 << c});
        end
        wr(8'h1B, 8'h7E);
        tick(3, 6'b011000);
        sts(8'h00);
        tick(1, 6'b111000);
        sts(8'hC0);
        tick(1, 6'b111101);
        sts(8'hC0);
        tick(1, 6'b111101);
        sts(8'hC8);
        tick(1, 6'b111101);
        sts(8'hE8);
        rd(8'h1C, 8'hE0);
        tick(2, 6'b100101);
        sts(8'hE8);
        tick(1, 6'b100101);
        sts(8'h00);
        wr(8'h1B, 8'h7A);
        tick(1, 6'b110000);
        sts(8'h40);
        tick(4, 6'b100000);
        sts(8'h40);
        tick(1, 6'b100000);
        sts(8'h00);
        // Insertion by ms ticks: sixteen of them take 150 to 170 clocks
        wr(8'h1B, 8'h00);
        tick(0, 6'b111000);
        repeat (130) @(posedge clk);
        #1 sts(8'h00);
        repeat (50) @(posedge clk);
        #1 sts(8'hC0);
        wr(8'h1E, 8'h48);
        act(4'b1000, 1'b1);
        chk("irqPin", {6'h0, serialOutIrq_q, serialOutIrqOe_q}, 8'h03);
        act(4'b0100, 1'b0);
        repeat (2) @(posedge clk);
        #1 chk("irqPin", {6'h0, serialOutIrq_q, serialOutIrqOe_q}, 8'h01);
        wr(8'h1E, 8'h08);
        act(4'b1000, 1'b0);
        act(4'b0010, 1'b1);
        act(4'b0001, 1'b0);
        wr(8'h1E, 8'h88);
        act(4'b1000, 1'b1);
        act(4'b0100, 1'b1);
        act(4'b0001, 1'b0);
        wr(8'h1E, 8'h48);
        @(posedge clk);
        adcRecording <= 1'b1;
        act(4'b1000, 1'b0);
        chk("procOe", {6'h0, activityProcEnable_q, serialOutIrqOe_q}, 8'h00);
        wr(8'h1E, 8'h4A);
        act(4'b1000, 1'b1);
        chk("procOe", {6'h0, activityProcEnable_q, serialOutIrqOe_q}, 8'h02);
        // Forbidden mode must ignore the end and power-down requests
        wr(8'h1E, 8'hCA);
        act(4'b0101, 1'b1);
        tallyAndFinish();
    end
endmodule // jack_detect_activity_cfg_tb

bind jdac_regs jdac_regs_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
    .clk(clk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdEn(regRdEn),
    .regRdData_q(regRdData_q),
    .headsetDetectEnable(headsetDetectEnable),
    .detTick(detTick),
    .jackPresentRaw(jackPresentRaw),
    .micPresentRaw(micPresentRaw),
    .headsetKindRaw(headsetKindRaw),
    .hookRaw(hookRaw),
    .activityStart(activityStart),
    .activityEnd(activityEnd),
    .adcRecording(adcRecording),
    .swAdcPowerUp(swAdcPowerUp),
    .swAdcPowerDown(swAdcPowerDown),
    .jackTypeStatus_q(jackTypeStatus_q),
    .headsetKindStatus_q(headsetKindStatus_q),
    .hookPressed_q(hookPressed_q),
    .adcPowerOn_q(adcPowerOn_q),
    .activityProcEnable_q(activityProcEnable_q),
    .monitoredChannelMask_q(monitoredChannelMask_q),
    .generatedChannelMask_q(generatedChannelMask_q),
    .serialOutIrq_q(serialOutIrq_q),
    .serialOutIrqOe_q(serialOutIrqOe_q)
);
